/* File: hdl/acpi_event_router_regs.vh */
`ifndef ACPI_EVENT_ROUTER_REGS_VH
`define ACPI_EVENT_ROUTER_REGS_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFF_PM1_STS1 8'h00
`define OFF_PM1_STS2 8'h01
`define OFF_PM1_EN1 8'h02
`define OFF_PM1_EN2 8'h03
`define OFF_PM1_CTL1 8'h04
`define OFF_PM1_CTL2 8'h05
`define OFF_GPE_STS1 8'h08
`define OFF_GPE_EN1 8'h09
`define OFF_WAKE_STS1 8'h0C
`define OFF_WAKE_STS2 8'h0D
`define OFF_WAKE_EN1 8'h0E
`define OFF_WAKE_EN2 8'h0F
`define OFF_GWAKE_STS 8'h10
`define OFF_GWAKE_EN 8'h11
`define OFF_SMI_STS1 8'h12
`define OFF_SMI_STS2 8'h13
`define OFF_SMI_EN1 8'h14
`define OFF_SMI_EN2 8'h15
`define OFF_MSC_STS 8'h16
`define OFF_IRQ_MUX 8'h18
`define OFF_SP_EN1 8'h19
`define OFF_SP_EN2 8'h1A
`define OFF_SP_STS1 8'h1B
`define OFF_SP_STS2 8'h1C
`define OFF_DEV_D3 8'h1D
`define OFF_BASE_LO 8'h1E
`define OFF_BASE_HI 8'h1F
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_PWRBTN 0
`define BIT_ALARM_SCI 1
`define BIT_OVERRIDE 2
`define BIT_WOKE 7
`define BIT_SCI_ROUTE 0
`define BIT_SLEEP_REQ 5
`define BIT_GPE_SCI 0
`define BIT_DEVINT 7
`define BIT_GLOBAL_WAKE 0
`define BIT_SMI_TO_WAKE 6
`define BIT_SMI_ROUTE 7
`define BIT_MUX_POL 0
`define BIT_MUX_PP 1
`define MUX_DEST_PIN 2'h0
`define MUX_DEST_IRQ11 2'h1
`define MUX_DEST_SERIRQ 2'h2
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_MUX 8'h00
`define RST_BASE 12'h000
`define CLK_KHZ 50000
`define OVERRIDE_MS 4000
`endif

/* File: hdl/sync_edge.v */
`timescale 1ns/1ps
module sync_edge #(
  parameter W = 1,
  parameter SYNC = 1
) (
  input wire clk,
  input wire rstn,
  input wire [W-1:0] d,
  output wire [W-1:0] lvl,
  output wire [W-1:0] rise
);
  reg [W-1:0] last_reg;
  generate
    if (SYNC != 0) begin : g_sync
      reg [W-1:0] s1_reg;
      reg [W-1:0] s2_reg;
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          s1_reg <= {W{1'b0}};
          s2_reg <= {W{1'b0}};
        end else begin
          s1_reg <= d;
          s2_reg <= s1_reg;
        end
      end
      assign lvl = s2_reg;
    end else begin : g_direct
      assign lvl = d;
    end
  endgenerate
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_reg <= {W{1'b0}};
    end else begin
      last_reg <= lvl;
    end
  end
  assign rise = lvl & ~last_reg;
endmodule // sync_edge

/* File: hdl/acpi_event_router.v */
// Behaviour
// - sci route enable steers events to SCI
// - smi route enable steers events to SMI
// - SCI goes to pin, IRQ11 or serial frame
// - no serial interrupt on standby power
// - SCI polarity and drive type from mux
// - power button status/enable raise SCI
// - button held 4 s forces off, override bits
// - alarm wake status sets, write one clears
// - alarm wake enable makes alarm a PME
// - alarm has separate SCI status/enable pair
// - enabled PME events also raise SCI
// - SMI events give SCI under joint enables
// - SMI events give PME under joint enables
// - enabled wakes power on, set woke status
// - rx_a and GPIO group B are SMI-derived SCI/PME; GPIO group A is also a direct PME source
// - non-wake SMI sources raise SMI, and SCI/PME via smi_via
// - configuration survives standby power-on reset
// - PME independent of PCI clock
// - listed sources directly assert PME
// - PME registers at 0Ch-11h, global gate
// - each function is D0 or D3
// - wake logic works with all in D3
// - runtime block base pointer held here
// - status sets regardless except override and woke bits, enable gates interrupt
// - no PME while global enable clear
// - global PME status sets regardless of enable
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "acpi_event_router_regs.vh"
module acpi_event_router #(
  parameter CNT_W = 28,
  parameter OVERRIDE_CYCLES = `OVERRIDE_MS * `CLK_KHZ
) (
  input wire core_clk,
  input wire rstn,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire ring_ind_a_n,
  input wire ring_ind_b_n,
  input wire modem_ring_n,
  input wire remote_ir_receiver,
  input wire keyboard_clock_in,
  input wire mouse_clock_in,
  input wire infrared_rx_b,
  input wire serial_rx_b,
  input wire serial_rx_a,
  input wire gpio_group_int_a,
  input wire gpio_group_int_b,
  input wire button_pressed,
  input wire standby_por_n,
  input wire standby_only,
  input wire alarm_event,
  input wire alarm_remember,
  input wire floppy_int,
  input wire parallel_int,
  input wire watchdog_event,
  input wire uart_a_int,
  input wire uart_b_int,
  input wire mouse_int,
  input wire keyboard_int,
  output reg smi_out,
  output reg pme_sci_o,
  output reg pme_sci_oe,
  output reg sci_irq11,
  output reg sci_serirq_req,
  output reg [3:0] sci_serirq_frame,
  output reg supply_on_n,
  output reg [7:0] dev_d3,
  output reg [11:0] pm_runtime_block
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [15:0] w1c;
    input [15:0] sts;
    input [15:0] clr;
    input [15:0] set;
    begin
      w1c = (sts & ~clr) | set;
    end
  endfunction
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction
  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  wire [12:0] pin_lvl;
  wire [12:0] pin_rise;
  wire [1:0] pwr_lvl;
  wire [7:0] int_rise;
  // active-low pins are inverted so every active transition is a rise
  sync_edge #(.W(13), .SYNC(1)) u_pins (
    .clk(core_clk),
    .rstn(rstn),
    .d({button_pressed, gpio_group_int_b, gpio_group_int_a, ~serial_rx_a,
        ~serial_rx_b, ~infrared_rx_b, 1'b0, ~mouse_clock_in, ~keyboard_clock_in,
        remote_ir_receiver, ~modem_ring_n, ~ring_ind_b_n, ~ring_ind_a_n}),
    .lvl(pin_lvl),
    .rise(pin_rise)
  );
  sync_edge #(.W(2), .SYNC(1)) u_pwr (
    .clk(core_clk),
    .rstn(rstn),
    .d({standby_only, ~standby_por_n}),
    .lvl(pwr_lvl),
    .rise()
  );
  sync_edge #(.W(8), .SYNC(0)) u_int (
    .clk(core_clk),
    .rstn(rstn),
    .d({alarm_event, keyboard_int, mouse_int, uart_b_int, uart_a_int,
        watchdog_event, parallel_int, floppy_int}),
    .lvl(),
    .rise(int_rise)
  );
  wire por_act = pwr_lvl[0];
  wire on_standby = pwr_lvl[1];
  wire alarm_rise = int_rise[7];
  // wake vector: 0-5 pins, 6 alarm, 7 ir_b, 8 rx_b, 9 rx_a, 10-11 gpio, 12 button
  wire [12:0] wake = {pin_rise[12:7], alarm_rise, pin_rise[5:0]};
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] pwr_sts_reg;
  reg [2:0] pwr_en_reg;
  reg sci_route_enable_reg;
  reg gpe_to_sci_enable_reg;
  reg [9:0] pme_sts_reg;
  reg [9:0] src_en_reg;
  reg device_int_wake_enable_reg;
  reg gwake_sts_reg;
  reg global_wake_enable_reg;
  reg [11:0] smi_sts_reg;
  reg [11:0] smi_en_reg;
  reg smi_to_wake_enable_reg;
  reg smi_route_enable_reg;
  reg [7:0] irq_mux_reg;
  reg [12:0] sp_en_reg;
  reg [12:0] sp_sts_reg;
  reg [7:0] dev_d3_reg;
  reg [11:0] base_reg;
  reg [CNT_W-1:0] hold_cnt_reg;
  reg override_done_reg;
  reg alarm_missed_reg;
  wire wr_ctl = wr & hit(addr, `OFF_PM1_CTL1);
  wire sleep_pulse = wr_ctl & wdata[`BIT_SLEEP_REQ];
  // ----------------------------------------------------------------
  // event sets
  // ----------------------------------------------------------------
  // pme source status: sources that reach the wake line directly
  wire [9:0] pme_set = {pin_rise[10], pin_rise[8], pin_rise[7], wake[6:0]};
  // smi status: non-wake sources, then smi-derived wake sources
  wire [11:0] smi_set = {pin_rise[12], pin_rise[11], pin_rise[10], pin_rise[9],
                         sleep_pulse, int_rise[6:0]};
  wire hold_hit = (hold_cnt_reg == OVERRIDE_CYCLES[CNT_W-1:0]);
  wire override_fire = hold_hit & ~override_done_reg & ~supply_on_n;
  wire ovr_evt = override_fire & pwr_en_reg[`BIT_OVERRIDE];
  wire [7:0] pm1_set = {|(wake & sp_en_reg), 4'h0, ovr_evt,
                        alarm_rise, pin_rise[12] & ~ovr_evt};
  wire any_wake_on = |(wake & sp_en_reg);
  // status: set wins over a same-cycle write-one clear
  wire [15:0] pwr_sts_next = w1c({8'h00, pwr_sts_reg},
    {8'h00, wr & hit(addr, `OFF_PM1_STS2) ? wdata : 8'h00},
    {8'h00, pm1_set}) & 16'h0087;
  wire [15:0] pme_sts_next = w1c({6'h00, pme_sts_reg},
    {6'h00, wr & hit(addr, `OFF_WAKE_STS2) ? wdata[2:0] : 3'h0,
     wr & hit(addr, `OFF_WAKE_STS1) ? wdata[6:0] : 7'h00},
    {6'h00, pme_set});
  wire [15:0] smi_sts_next = w1c({4'h0, smi_sts_reg},
    {4'h0, wr & hit(addr, `OFF_SMI_STS2) ? wdata[3:0] : 4'h0,
     wr & hit(addr, `OFF_SMI_STS1) ? wdata : 8'h00},
    {4'h0, smi_set});
  wire [15:0] sp_sts_next = w1c({3'h0, sp_sts_reg},
    {3'h0, wr & hit(addr, `OFF_SP_STS2) ? wdata[4:0] : 5'h00,
     wr & hit(addr, `OFF_SP_STS1) ? wdata : 8'h00},
    {3'h0, wake});
  // ----------------------------------------------------------------
  // interrupt routing
  // ----------------------------------------------------------------
  wire smi_any = |(smi_sts_reg & smi_en_reg);
  wire smi_via = device_int_wake_enable_reg & smi_to_wake_enable_reg & smi_any;
  wire pme_any = |(pme_sts_reg & src_en_reg);
  // no pme assertion while the global gate is off
  wire pme_act = global_wake_enable_reg & (pme_any | smi_via);
  wire pm1_any = |(pwr_sts_reg[2:0] & pwr_en_reg);
  wire sci_act = sci_route_enable_reg &
                 (pm1_any | (gpe_to_sci_enable_reg & pme_any) | smi_via);
  wire smi_act = smi_route_enable_reg & smi_any;
  wire [1:0] dest = irq_mux_reg[3:2];
  wire sci_lvl = irq_mux_reg[`BIT_MUX_POL] ? sci_act : ~sci_act;
  // ----------------------------------------------------------------
  // register writes and events
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pwr_sts_reg <= `RST_BYTE;
      pwr_en_reg <= 3'h0;
      sci_route_enable_reg <= 1'b0;
      gpe_to_sci_enable_reg <= 1'b0;
      pme_sts_reg <= 10'h000;
      src_en_reg <= 10'h000;
      device_int_wake_enable_reg <= 1'b0;
      gwake_sts_reg <= 1'b0;
      global_wake_enable_reg <= 1'b0;
      smi_sts_reg <= 12'h000;
      smi_en_reg <= 12'h000;
      smi_to_wake_enable_reg <= 1'b0;
      smi_route_enable_reg <= 1'b0;
      irq_mux_reg <= `RST_MUX;
      sp_en_reg <= 13'h0000;
      sp_sts_reg <= 13'h0000;
      dev_d3_reg <= `RST_BYTE;
      base_reg <= `RST_BASE;
    end else if (por_act) begin
      // standby reset clears status only; configuration is battery held
      pwr_sts_reg <= `RST_BYTE;
      pme_sts_reg <= 10'h000;
      gwake_sts_reg <= 1'b0;
      smi_sts_reg <= 12'h000;
      sp_sts_reg <= 13'h0000;
    end else begin
      pwr_sts_reg <= pwr_sts_next[7:0];
      if (ovr_evt) begin
        pwr_sts_reg[`BIT_PWRBTN] <= 1'b0;
      end
      pme_sts_reg <= pme_sts_next[9:0];
      gwake_sts_reg <= (gwake_sts_reg & ~(wr & hit(addr, `OFF_GWAKE_STS) & wdata[0]))
                       | (|pme_set);
      smi_sts_reg <= smi_sts_next[11:0];
      sp_sts_reg <= sp_sts_next[12:0];
      if (wr) begin
        case (addr)
          `OFF_PM1_EN2: pwr_en_reg <= wdata[2:0];
          `OFF_PM1_CTL1: sci_route_enable_reg <= wdata[`BIT_SCI_ROUTE];
          `OFF_GPE_EN1: gpe_to_sci_enable_reg <= wdata[`BIT_GPE_SCI];
          `OFF_WAKE_EN1: begin
            src_en_reg[6:0] <= wdata[6:0];
            device_int_wake_enable_reg <= wdata[`BIT_DEVINT];
          end
          `OFF_WAKE_EN2: src_en_reg[9:7] <= wdata[2:0];
          `OFF_GWAKE_EN: global_wake_enable_reg <= wdata[`BIT_GLOBAL_WAKE];
          `OFF_SMI_EN1: smi_en_reg[7:0] <= wdata;
          `OFF_SMI_EN2: begin
            smi_en_reg[11:8] <= wdata[3:0];
            smi_to_wake_enable_reg <= wdata[`BIT_SMI_TO_WAKE];
            smi_route_enable_reg <= wdata[`BIT_SMI_ROUTE];
          end
          `OFF_IRQ_MUX: irq_mux_reg <= wdata;
          `OFF_SP_EN1: sp_en_reg[7:0] <= wdata;
          `OFF_SP_EN2: sp_en_reg[12:8] <= wdata[4:0];
          `OFF_DEV_D3: dev_d3_reg <= wdata;
          `OFF_BASE_LO: base_reg[7:0] <= wdata;
          `OFF_BASE_HI: base_reg[11:8] <= wdata[3:0];
          default: ;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // button override and supply control
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hold_cnt_reg <= {CNT_W{1'b0}};
      override_done_reg <= 1'b0;
      alarm_missed_reg <= 1'b0;
      supply_on_n <= 1'b1;
    end else begin
      // counts only while held; one firing per press
      if (!pin_lvl[12]) begin
        hold_cnt_reg <= {CNT_W{1'b0}};
        override_done_reg <= 1'b0;
      end else if (!hold_hit) begin
        hold_cnt_reg <= hold_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (override_fire) begin
        override_done_reg <= 1'b1;
      end
      // a remembered alarm on standby return powers on once
      alarm_missed_reg <= por_act & alarm_remember;
      if (ovr_evt) begin
        supply_on_n <= 1'b1;
      end else if (any_wake_on | (alarm_missed_reg & ~por_act & sp_en_reg[6])) begin
        supply_on_n <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  // pme is a registered level of status and enables, clocked by core_clk like the register port
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      smi_out <= 1'b0;
      pme_sci_o <= 1'b0;
      pme_sci_oe <= 1'b0;
      sci_irq11 <= 1'b0;
      sci_serirq_req <= 1'b0;
      sci_serirq_frame <= 4'h0;
      dev_d3 <= `RST_BYTE;
      pm_runtime_block <= `RST_BASE;
    end else begin
      smi_out <= smi_act;
      if (dest == `MUX_DEST_PIN) begin
        pme_sci_o <= irq_mux_reg[`BIT_MUX_PP] ? sci_lvl : 1'b0;
        pme_sci_oe <= irq_mux_reg[`BIT_MUX_PP] | ~sci_lvl;
      end else begin
        pme_sci_o <= 1'b0;
        pme_sci_oe <= pme_act;
      end
      sci_irq11 <= (dest == `MUX_DEST_IRQ11) & sci_act;
      sci_serirq_req <= (dest == `MUX_DEST_SERIRQ) & sci_act & ~on_standby;
      sci_serirq_frame <= irq_mux_reg[7:4];
      dev_d3 <= dev_d3_reg;
      pm_runtime_block <= base_reg;
    end
  end
  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= `RST_BYTE;
    end else if (rd) begin
      case (addr)
        `OFF_PM1_STS2: rdata <= pwr_sts_reg;
        `OFF_PM1_EN2: rdata <= {5'h00, pwr_en_reg};
        `OFF_PM1_CTL1: rdata <= {7'h00, sci_route_enable_reg};
        `OFF_GPE_STS1: rdata <= {7'h00, pme_any};
        `OFF_GPE_EN1: rdata <= {7'h00, gpe_to_sci_enable_reg};
        `OFF_WAKE_STS1: rdata <= {1'b0, pme_sts_reg[6:0]};
        `OFF_WAKE_STS2: rdata <= {5'h00, pme_sts_reg[9:7]};
        `OFF_WAKE_EN1: rdata <= {device_int_wake_enable_reg, src_en_reg[6:0]};
        `OFF_WAKE_EN2: rdata <= {5'h00, src_en_reg[9:7]};
        `OFF_GWAKE_STS: rdata <= {7'h00, gwake_sts_reg};
        `OFF_GWAKE_EN: rdata <= {7'h00, global_wake_enable_reg};
        `OFF_SMI_STS1: rdata <= smi_sts_reg[7:0];
        `OFF_SMI_STS2: rdata <= {4'h0, smi_sts_reg[11:8]};
        `OFF_SMI_EN1: rdata <= smi_en_reg[7:0];
        `OFF_SMI_EN2: rdata <= {smi_route_enable_reg, smi_to_wake_enable_reg, 2'h0,
                                smi_en_reg[11:8]};
        `OFF_IRQ_MUX: rdata <= irq_mux_reg;
        `OFF_SP_EN1: rdata <= sp_en_reg[7:0];
        `OFF_SP_EN2: rdata <= {3'h0, sp_en_reg[12:8]};
        `OFF_SP_STS1: rdata <= sp_sts_reg[7:0];
        `OFF_SP_STS2: rdata <= {3'h0, sp_sts_reg[12:8]};
        `OFF_DEV_D3: rdata <= dev_d3_reg;
        `OFF_BASE_LO: rdata <= base_reg[7:0];
        `OFF_BASE_HI: rdata <= {4'h0, base_reg[11:8]};
        default: rdata <= `RST_BYTE;
      endcase
    end else begin
      rdata <= `RST_BYTE;
    end
  end
endmodule // acpi_event_router

/* File: sim/host_irq_sink.sv */
`timescale 1ns/1ps
module host_irq_sink (
  input wire pme_sci_o,
  input wire pme_sci_oe,
  output wire pme_line
);
  // --------------------------------------------------------------
  // board wire with pull-up; a released pin floats high
  // --------------------------------------------------------------
  assign pme_line = pme_sci_oe ? pme_sci_o : 1'b1;
endmodule // host_irq_sink

/* File: sim/acpi_event_router_sva.sv */
`timescale 1ns/1ps
module acpi_event_router_chk (
  input wire core_clk,
  input wire rstn,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire standby_only,
  input wire pme_sci_o,
  input wire pme_sci_oe,
  input wire sci_irq11,
  input wire sci_serirq_req,
  input wire [3:0] sci_serirq_frame,
  input wire smi_out
);
  // --------------------------------------------------------------
  // shadow of software-written configuration
  // --------------------------------------------------------------
  reg gwe, gwe_a, gwe_d, slp_on, route, route_d;
  reg [7:0] mux, mux_a, mux_d;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gwe <= 1'b0;
      slp_on <= 1'b0;
      route <= 1'b0;
      mux <= 8'h00;
    end else if (wr) begin
      case (addr)
        8'h11: gwe <= wdata[0];
        8'h14: slp_on <= wdata[7];
        8'h15: route <= wdata[7];
        8'h18: mux <= wdata;
        default: ;
      endcase
    end
  end
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gwe_a <= 1'b0;
      gwe_d <= 1'b0;
      route_d <= 1'b0;
      mux_a <= 8'h00;
      mux_d <= 8'h00;
    end else begin
      gwe_a <= gwe;
      gwe_d <= gwe_a;
      route_d <= route;
      mux_a <= mux;
      mux_d <= mux_a;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence sleep_write;
    wr && addr == 8'h04 && wdata[5] && slp_on && route;
  endsequence
  sequence smi_raised;
    ##[1:4] smi_out;
  endsequence
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  AST_PME_GATE:
    assert property ((!gwe && !gwe_d && mux[3:2] != 2'h0 && mux == mux_d)
      |-> !(pme_sci_oe && !pme_sci_o)) else $error("pme pin driven while gated");
  AST_SERIRQ_STANDBY:
    assert property (standby_only [*5] |-> !sci_serirq_req) else $error("serirq on standby");
  AST_IDLE_RDATA:
    assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  AST_UNMAPPED_READ:
    assert property (rd && addr[7:5] != 3'h0 |=> rdata == 8'h00) else $error("unmapped read");
  AST_GLOBAL_READBACK:
    assert property (rd && addr == 8'h11 |=> rdata == {7'h00, gwe}) else $error("gwe readback");
  AST_IRQ11_DEST:
    assert property (sci_irq11 && mux == mux_d |-> mux[3:2] == 2'h1) else $error("irq11 dest");
  AST_SERIRQ_FRAME:
    assert property (sci_serirq_req && mux == mux_d |-> mux[3:2] == 2'h2
      && sci_serirq_frame == mux[7:4]) else $error("serirq frame");
  AST_SLEEP_SMI:
    assert property (sleep_write |-> smi_raised) else $error("sleep smi missing");
  AST_SMI_ROUTE:
    assert property (!route && !route_d |-> !smi_out) else $error("smi without route");
endmodule // acpi_event_router_chk

bind acpi_event_router acpi_event_router_chk acpi_event_router_chk_i (
  .core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .standby_only(standby_only), .pme_sci_o(pme_sci_o),
  .pme_sci_oe(pme_sci_oe), .sci_irq11(sci_irq11), .sci_serirq_req(sci_serirq_req),
  .sci_serirq_frame(sci_serirq_frame), .smi_out(smi_out));

/* File: sim/acpi_event_router_tb_top.sv */
`timescale 1ns/1ps
module acpi_event_router_tb_top;
  localparam [10:0] WK_IDLE = 11'h2F7;
  reg core_clk, rstn, wr, rd, button_pressed, standby_por_n, standby_only, alarm_event;
  reg alarm_remember;
  reg [7:0] addr, wdata;
  reg [10:0] wk;
  reg [6:0] smi_src;
  wire [7:0] rdata, dev_d3;
  wire smi_out, pme_sci_o, pme_sci_oe, sci_irq11, sci_serirq_req, supply_on_n, pme_line;
  wire [3:0] sci_serirq_frame;
  wire [11:0] pm_runtime_block;
  integer fail_count, comparisons, cycles, i;
  acpi_event_router #(.OVERRIDE_CYCLES(20)) acpi_event_router_i (
    .core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ring_ind_a_n(wk[0]), .ring_ind_b_n(wk[1]), .modem_ring_n(wk[2]),
    .remote_ir_receiver(wk[3]), .keyboard_clock_in(wk[4]), .mouse_clock_in(wk[5]),
    .infrared_rx_b(wk[6]), .serial_rx_b(wk[7]), .gpio_group_int_a(wk[8]),
    .serial_rx_a(wk[9]), .gpio_group_int_b(wk[10]), .button_pressed(button_pressed),
    .standby_por_n(standby_por_n), .standby_only(standby_only), .alarm_event(alarm_event),
    .alarm_remember(alarm_remember), .floppy_int(smi_src[0]), .parallel_int(smi_src[1]),
    .watchdog_event(smi_src[2]), .uart_a_int(smi_src[3]), .uart_b_int(smi_src[4]),
    .mouse_int(smi_src[5]), .keyboard_int(smi_src[6]), .smi_out(smi_out),
    .pme_sci_o(pme_sci_o), .pme_sci_oe(pme_sci_oe), .sci_irq11(sci_irq11),
    .sci_serirq_req(sci_serirq_req), .sci_serirq_frame(sci_serirq_frame),
    .supply_on_n(supply_on_n), .dev_d3(dev_d3), .pm_runtime_block(pm_runtime_block));
  host_irq_sink host_irq_sink_i (.pme_sci_o(pme_sci_o), .pme_sci_oe(pme_sci_oe),
    .pme_line(pme_line));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // --------------------------------------------------------------
  // bus and check tasks
  // --------------------------------------------------------------
  task chk(input string nm, input [11:0] exp, input [11:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fail_count = fail_count + 1;
    end
  endtask
  task chk1(input string nm, input e, input g);
    chk(nm, {11'h000, e}, {11'h000, g});
  endtask
  task settle(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input [7:0] a, input [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {4'h0, e}, {4'h0, rdata});
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {rstn, wr, rd, button_pressed, standby_only, alarm_event, alarm_remember} = 7'h00;
    standby_por_n = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wk = WK_IDLE;
    smi_src = 7'h00;
    {fail_count, comparisons, cycles} = 0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h40, 8'h00);
    chk1("supply", 1'b1, supply_on_n);
    $display("test reset done");
    wr_reg(8'h18, 8'h07);
    wr_reg(8'h04, 8'h01);
    @(posedge core_clk);
    alarm_event <= 1'b1;
    @(posedge core_clk);
    alarm_event <= 1'b0;
    settle(3);
    chk1("irq11 masked", 1'b0, sci_irq11);
    chk1("pme gated", 1'b1, pme_line);
    rd_chk(8'h0C, 8'h40);
    rd_chk(8'h10, 8'h01);
    wr_reg(8'h03, 8'h02);
    settle(2);
    chk1("alarm sci", 1'b1, sci_irq11);
    wr_reg(8'h18, 8'h03);
    settle(2);
    chk("pin high pp", 12'h3, {10'h000, pme_sci_oe, pme_sci_o});
    wr_reg(8'h18, 8'h00);
    settle(2);
    chk("pin low od", 12'h2, {10'h000, pme_sci_oe, pme_sci_o});
    wr_reg(8'h18, 8'h07);
    wr_reg(8'h04, 8'h00);
    settle(2);
    chk1("sci unrouted", 1'b0, sci_irq11);
    wr_reg(8'h04, 8'h01);
    wr_reg(8'h01, 8'h00);
    rd_chk(8'h01, 8'h02);
    wr_reg(8'h01, 8'h02);
    settle(2);
    chk1("sci cleared", 1'b0, sci_irq11);
    $display("test alarm sci done");
    wr_reg(8'h0E, 8'h40);
    wr_reg(8'h11, 8'h01);
    settle(2);
    chk1("alarm pme", 1'b0, pme_line);
    wr_reg(8'h11, 8'h00);
    settle(2);
    chk1("pme off", 1'b1, pme_line);
    wr_reg(8'h11, 8'h01);
    wr_reg(8'h09, 8'h01);
    settle(2);
    chk1("gpe sci", 1'b1, sci_irq11);
    wr_reg(8'h0C, 8'h00);
    settle(2);
    chk1("pme held", 1'b0, pme_line);
    wr_reg(8'h0C, 8'h40);
    wr_reg(8'h10, 8'h01);
    settle(2);
    chk1("pme released", 1'b1, pme_line);
    chk1("gpe released", 1'b0, sci_irq11);
    $display("test alarm pme done");
    wr_reg(8'h14, 8'hFF);
    wr_reg(8'h15, 8'h80);
    for (i = 0; i < 7; i = i + 1) begin
      @(posedge core_clk);
      smi_src[i] <= 1'b1;
      @(posedge core_clk);
      smi_src[i] <= 1'b0;
      settle(2);
      chk1("smi", 1'b1, smi_out);
      rd_chk(8'h12, 8'h01 << i);
      wr_reg(8'h12, 8'hFF);
      settle(2);
      chk1("smi clear", 1'b0, smi_out);
    end
    wr_reg(8'h04, 8'h21);
    settle(2);
    rd_chk(8'h12, 8'h80);
    wr_reg(8'h12, 8'hFF);
    @(posedge core_clk);
    smi_src[0] <= 1'b1;
    @(posedge core_clk);
    smi_src[0] <= 1'b0;
    settle(2);
    chk1("smi no sci", 1'b0, sci_irq11);
    wr_reg(8'h0E, 8'hC0);
    wr_reg(8'h15, 8'hC0);
    settle(2);
    chk1("smi pme", 1'b0, pme_line);
    chk1("smi sci", 1'b1, sci_irq11);
    wr_reg(8'h15, 8'h80);
    settle(2);
    chk1("smi pme off", 1'b1, pme_line);
    wr_reg(8'h12, 8'hFF);
    $display("test smi done");
    wr_reg(8'h1D, 8'hFF);
    settle(2);
    chk("d3", 12'h0FF, {4'h0, dev_d3});
    for (i = 0; i < 11; i = i + 1) begin
      wr_reg(8'h0C, 8'hFF);
      wr_reg(8'h0D, 8'hFF);
      wr_reg(8'h13, 8'hFF);
      @(posedge core_clk);
      wk[i] <= ~WK_IDLE[i];
      @(posedge core_clk);
      wk[i] <= WK_IDLE[i];
      settle(4);
      rd_chk(i < 6 ? 8'h0C : i < 9 ? 8'h0D : 8'h13,
        8'h01 << (i < 6 ? i : i < 9 ? i - 6 : (i - 9) * 2));
    end
    $display("test wake sources done");
    wr_reg(8'h1A, 8'h10);
    wr_reg(8'h03, 8'h05);
    wr_reg(8'h01, 8'hFF);
    @(posedge core_clk);
    button_pressed <= 1'b1;
    settle(6);
    chk1("supply on", 1'b0, supply_on_n);
    chk1("button sci", 1'b1, sci_irq11);
    rd_chk(8'h01, 8'h81);
    settle(30);
    rd_chk(8'h01, 8'h84);
    chk1("supply off", 1'b1, supply_on_n);
    @(posedge core_clk);
    button_pressed <= 1'b0;
    $display("test button done");
    wr_reg(8'h1E, 8'h34);
    wr_reg(8'h1F, 8'h02);
    wr_reg(8'h18, 8'h5B);
    settle(2);
    chk("base", 12'h234, pm_runtime_block);
    chk1("serirq", 1'b1, sci_serirq_req);
    chk("frame", 12'h005, {8'h00, sci_serirq_frame});
    @(posedge core_clk);
    standby_only <= 1'b1;
    settle(6);
    chk1("serirq standby", 1'b0, sci_serirq_req);
    @(posedge core_clk);
    standby_only <= 1'b0;
    $display("test routing done");
    @(posedge core_clk);
    standby_por_n <= 1'b0;
    settle(5);
    @(posedge core_clk);
    standby_por_n <= 1'b1;
    settle(3);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h11, 8'h01);
    rd_chk(8'h18, 8'h5B);
    $display("test standby reset done");
    end_of_test;
  end
endmodule // acpi_event_router_tb_top
